// ===== verilog/dcl_pkg.sv
// Purpose: Shared constants and types for the direct-connect line interface.
// Assumes: Byte-wide registers on a plain strobe port with a 3-bit address.
// Notes:   Register field layouts and reset values live here; status and readback bit slots are placed in dcl_line_iface.
package dcl_pkg;

	// Register addresses on the plain register port.
	localparam int           DCL_ADDR_W       = 3;
	localparam logic [2:0]   DCL_ADDR_LOOP_ID = 3'h0;
	localparam logic [2:0]   DCL_ADDR_LINECTL = 3'h2;
	localparam logic [2:0]   DCL_ADDR_OPTION  = 3'h4;
	localparam logic [2:0]   DCL_ADDR_STATUS  = 3'h5;

	// Field positions inside the byte-wide registers.
	localparam int           DCL_LC_CONTROL_BIT   = 0;
	localparam int           DCL_LC_RTS_BIT       = 1;
	localparam int           DCL_LC_LOOP_A_BIT    = 7;
	localparam int           DCL_OPT_CTL_SEL_BIT  = 0;
	localparam int           DCL_OPT_CLK_SRC_BIT  = 1;
	localparam int           DCL_OPT_LOOP_B_BIT   = 6;
	localparam int           DCL_ID_LSB           = 2;

	// Reset values of the write-only registers.
	localparam logic [7:0]   DCL_LINECTL_RESET = 8'h00;
	localparam logic [7:0]   DCL_OPTION_RESET  = 8'h00;

	// Fixed status bits: bits 2 and 3 high, bits 4, 5 and 7 low.
	localparam logic [7:0]   DCL_STATUS_ONES   = 8'h0c;
	localparam logic [7:0]   DCL_STATUS_ZEROS  = 8'hb0;

	// Marking level of the outgoing send-data line.
	localparam logic         DCL_MARK          = 1'b1;

	// Read data shown outside the one answer cycle or for a hole in the map.
	localparam logic [7:0]   DCL_READ_IDLE     = 8'h00;

	// Period of the receive timing line in the bench, in nanoseconds.
	localparam int           DCL_LINK_PERIOD_NS = 200;

	// Line-control register fields, most significant first.
	typedef struct packed {
		logic       test_loop_a_write;
		logic [4:0] spare;
		logic       request_to_send_bit;
		logic       control_line_out;
	} dcl_linectl_t;

	// Option register fields, most significant first.
	typedef struct packed {
		logic       spare_hi;
		logic       test_loop_b_write;
		logic [3:0] spare_mid;
		logic       clk_src_copy;
		logic       control_interface_select;
	} dcl_option_t;

	// Incoming line levels after synchronisation.
	typedef struct packed {
		logic receive_timing_line;
		logic indicator_line;
		logic receive_data_line;
	} dcl_line_in_t;

endpackage

// ===== verilog/dcl_sync2.sv
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: Inputs arrive from pins outside the SYS_CLK domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module dcl_sync2
	import dcl_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// Stages hold while the clock enable is low.
	always_comb begin
		meta_d = ce ? async_in : meta_q;
		sync_d = ce ? meta_q : sync_q;
	end

	// Both stages clear to zero under reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule

// ===== verilog/dcl_line_iface.sv
// Purpose: Register bank and signal routing of the balanced-line
//          direct-connect line interface.
// Assumes: SYS_CLK at 40 MHz; line inputs are asynchronous and synchronised.
// Notes:   Registers sit on a plain strobe port; read data lasts one cycle.
//
// Notes on behaviour
// - Readback bits 0,1 mirror both test-loop bits.
// - Readback bits 2..7 carry interface identification code.
// - Control bit 0 drives outgoing control line.
// - Request-to-send reads back as clear-to-send.
// - Test loop A routes transmit data to receive.
// - During loop, send-data line held at mark (loop A only; the loop B bit moves no line).
// - Select one: status bit 0 shows indicator.
// - Select zero: status bit 0 follows control bit.
// - Status bits 2 and 3 read one.
// - Status bits 4, 5, 7 read zero.
// - Status bit 6 shows receive-data line level.
// - Option bit 1 is stored but ignored.
`timescale 1ns/1ps
module dcl_line_iface
	import dcl_pkg::*;
#(
	parameter logic [5:0] ID_CODE = 6'h2a // Arbitrary neutral identifier.
) (
	input  wire logic                  SYS_CLK,
	input  wire logic                  NRST,
	input  wire logic                  CE,
	input  wire logic [DCL_ADDR_W-1:0] ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [7:0]            RDATA,
	input  wire logic                  TX_DATA,
	input  wire logic                  TX_CLK,
	output logic                       RX_DATA,
	output logic                       RX_TIMING,
	output logic                       RX_TIMING_RISE,
	output logic                       SEND_DATA_LINE,
	output logic                       CONTROL_LINE_OUT,
	output logic                       TERMINAL_TIMING_LINE,
	input  wire logic                  RECEIVE_DATA_LINE,
	input  wire logic                  INDICATOR_LINE,
	input  wire logic                  RECEIVE_TIMING_LINE
);

	// Register state and its next values.
	dcl_linectl_t linectl_q;
	dcl_linectl_t linectl_d;
	dcl_option_t  option_q;
	dcl_option_t  option_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;

	// Line-side state and its next values.
	logic         send_q;
	logic         send_d;
	logic         rx_q;
	logic         rx_d;
	logic         ctl_out_q;
	logic         ctl_out_d;
	logic         tt_q;
	logic         tt_d;
	logic         rt_prev_q;
	logic         rt_prev_d;
	logic         rt_rise_q;
	logic         rt_rise_d;

	// Combinational views.
	dcl_line_in_t line_in;
	logic         loop_active;
	logic [7:0]   loop_id_view;
	logic [7:0]   status_view;

	// Every incoming line input crosses two flip-flops before any logic reads it.
	dcl_sync2 #(
		.WIDTH ($bits(dcl_line_in_t))
	) u_sync (
		.clk      (SYS_CLK),
		.rst_n    (NRST),
		.ce       (CE),
		.async_in ({RECEIVE_TIMING_LINE, INDICATOR_LINE, RECEIVE_DATA_LINE}),
		.sync_out (line_in)
	);

	assign loop_active = linectl_q.test_loop_a_write;

	// Readback: loop bits below, identifier above.  The adapter strips
	// the loop bits itself when it wants the bare identifier, so they are
	// always presented here.
	always_comb begin
		loop_id_view                = '0;
		loop_id_view[0]             = linectl_q.test_loop_a_write;
		loop_id_view[1]             = option_q.test_loop_b_write;
		loop_id_view[7:DCL_ID_LSB]  = ID_CODE;
	end

	// Status view is rebuilt every cycle from live lines and held bits.
	always_comb begin
		status_view    = DCL_STATUS_ONES;
		status_view    = status_view & ~DCL_STATUS_ZEROS;
		if (option_q.control_interface_select) begin
			status_view[0] = line_in.indicator_line;
		end else begin
			status_view[0] = linectl_q.control_line_out;
		end
		status_view[1] = linectl_q.request_to_send_bit;
		status_view[6] = line_in.receive_data_line;
	end

	// Register writes and the one-cycle read answer.  Writes to readback
	// or status addresses, and unmapped addresses, change nothing.
	always_comb begin
		linectl_d = linectl_q;
		option_d  = option_q;
		rdata_d   = DCL_READ_IDLE;
		if (CE) begin
			if (WR) begin
				case (ADDR)
					DCL_ADDR_LINECTL: begin
						linectl_d = dcl_linectl_t'(WDATA);
					end
					DCL_ADDR_OPTION: begin
						// The clock-source copy is kept but steers nothing.
						option_d = dcl_option_t'(WDATA);
					end
					default: begin
						linectl_d = linectl_q;
					end
				endcase
			end
			if (RD) begin
				case (ADDR)
					DCL_ADDR_LOOP_ID: rdata_d = loop_id_view;
					DCL_ADDR_STATUS:  rdata_d = status_view;
					default:          rdata_d = DCL_READ_IDLE;
				endcase
			end
		end else begin
			rdata_d = rdata_q;
		end
	end

	// Register state; the write-only registers hold until rewritten.
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			linectl_q <= dcl_linectl_t'(DCL_LINECTL_RESET);
			option_q  <= dcl_option_t'(DCL_OPTION_RESET);
			rdata_q   <= DCL_READ_IDLE;
		end else begin
			linectl_q <= linectl_d;
			option_q  <= option_d;
			rdata_q   <= rdata_d;
		end
	end

	// Line routing.  Loopback is taken at the driver input, so the far
	// end sees steady mark rather than the looped data.  Transmit clock
	// selection is the adapter's job; its chosen clock simply leaves as
	// terminal timing through one register, the same one-cycle delay as the data.
	always_comb begin
		send_d    = send_q;
		rx_d      = rx_q;
		ctl_out_d = ctl_out_q;
		tt_d      = tt_q;
		rt_prev_d = rt_prev_q;
		rt_rise_d = 1'b0;
		if (CE) begin
			ctl_out_d = linectl_q.control_line_out;
			tt_d      = TX_CLK;
			if (loop_active) begin
				send_d = DCL_MARK;
				rx_d   = TX_DATA;
			end else begin
				send_d = TX_DATA;
				rx_d   = line_in.receive_data_line;
			end
			rt_prev_d = line_in.receive_timing_line;
			rt_rise_d = line_in.receive_timing_line & ~rt_prev_q;
		end
	end

	// Line-side registers; the send line idles at mark out of reset.
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			send_q    <= DCL_MARK;
			rx_q      <= DCL_MARK;
			ctl_out_q <= 1'b0;
			tt_q      <= 1'b0;
			rt_prev_q <= 1'b0;
			rt_rise_q <= 1'b0;
		end else begin
			send_q    <= send_d;
			rx_q      <= rx_d;
			ctl_out_q <= ctl_out_d;
			tt_q      <= tt_d;
			rt_prev_q <= rt_prev_d;
			rt_rise_q <= rt_rise_d;
		end
	end

	// All outputs come straight from flip-flops.
	assign RDATA                = rdata_q;
	assign RX_DATA              = rx_q;
	assign RX_TIMING            = rt_prev_q;
	assign RX_TIMING_RISE       = rt_rise_q;
	assign SEND_DATA_LINE       = send_q;
	assign CONTROL_LINE_OUT     = ctl_out_q;
	assign TERMINAL_TIMING_LINE = tt_q;

endmodule

// ===== tb/dcl_line_iface_monitor.sv
// Purpose: Port checker of the line interface register bank.
// Assumes: CE high around each watched access.
// Notes:   Routed outputs settle two edges after a write.
`timescale 1ns/1ps
module dcl_line_iface_monitor
	import dcl_pkg::*;
#(
	parameter logic [5:0] ID_CODE = 6'h2a
) (
	input wire logic       SYS_CLK,
	input wire logic       NRST,
	input wire logic       CE,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       TX_DATA,
	input wire logic       RX_DATA,
	input wire logic       SEND_DATA_LINE,
	input wire logic       CONTROL_LINE_OUT,
	input wire logic       TX_CLK,
	input wire logic       TERMINAL_TIMING_LINE,
	input wire logic       RX_TIMING,
	input wire logic       RX_TIMING_RISE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	// Access steps on the register port.
	sequence wr_lc; CE && WR && ADDR == DCL_ADDR_LINECTL; endsequence
	sequence loop_on; wr_lc ##0 WDATA[7]; endsequence
	sequence rd_id; CE && RD && ADDR == DCL_ADDR_LOOP_ID; endsequence
	sequence rd_st; CE && RD && ADDR == DCL_ADDR_STATUS; endsequence

	id_code_a: assert property (rd_id |=> RDATA[7:2] == ID_CODE)
		else $error("id code");
	loop_rb_a: assert property (wr_lc ##1 rd_id |=>
		RDATA[0] == $past(WDATA[7], 2)) else $error("loop readback");
	rts_echo_a: assert property (wr_lc ##1 rd_st |=>
		RDATA[1] == $past(WDATA[1], 2)) else $error("rts echo");
	ones_a: assert property (rd_st |=> RDATA[3:2] == 2'b11)
		else $error("status ones");
	zeros_a: assert property (rd_st |=> !RDATA[7] && !RDATA[5:4])
		else $error("status zeros");
	ctl_out_a: assert property (wr_lc ##2 1'b1 |->
		CONTROL_LINE_OUT == $past(WDATA[0], 2)) else $error("control line");
	mark_a: assert property (loop_on ##2 1'b1 |-> SEND_DATA_LINE)
		else $error("send line off mark");
	wrap_a: assert property (loop_on ##2 1'b1 |->
		RX_DATA == $past(TX_DATA)) else $error("loopback data");
	tt_follow_a: assert property ($past(CE) |->
		TERMINAL_TIMING_LINE == $past(TX_CLK)) else $error("terminal timing");
	rt_rise_a: assert property (RX_TIMING_RISE |->
		RX_TIMING && !$past(RX_TIMING)) else $error("timing rise pulse");
endmodule
bind dcl_line_iface dcl_line_iface_monitor #(.ID_CODE(ID_CODE)) u_mon (.*);

// ===== tb/dcl_remote_term.sv
// Purpose: Remote terminal at the far end of the balanced link.
// Assumes: The bench chooses the levels the terminal sends.
// Notes:   Receive timing runs only while run is high.
`timescale 1ns/1ps
module dcl_remote_term (
	input  wire logic run,
	input  wire logic rd_lvl,
	input  wire logic ind_lvl,
	output logic      rd_line,
	output logic      ind_line,
	output logic      rt_line = 1'b0
);
	// Held levels; timing rests low between frames, 200 ns a period.
	assign rd_line = rd_lvl;
	assign ind_line = ind_lvl;
	always #100 rt_line = run & ~rt_line;
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench of the line interface register bank.
// Assumes: The bench plays the adapter; a terminal model drives the line.
// Notes:   CE is lowered once to show that a write is refused then.
`timescale 1ns/1ps
module tb
	import dcl_pkg::*;
;
	localparam logic [5:0] ID = 6'h15; // Arbitrary value.
	logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
	logic       tx = 1'b1, txc = 1'b0, src = 1'b0, run = 1'b0;
	logic       rd_lvl = 1'b0, ind_lvl = 1'b0, ce = 1'b1;
	logic       rx, rx_t, sdl, rdl, indl, rtl;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata;
	int         n_mismatch = 0, checks = 0;

	always #12.5 clk = ~clk;
	dcl_line_iface #(.ID_CODE(ID)) DUT (
		.SYS_CLK(clk), .NRST(nrst), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_DATA(tx),
		.TX_CLK(txc), .RX_DATA(rx), .RX_TIMING(rx_t), .RX_TIMING_RISE(),
		.SEND_DATA_LINE(sdl), .CONTROL_LINE_OUT(),
		.TERMINAL_TIMING_LINE(), .RECEIVE_DATA_LINE(rdl),
		.INDICATOR_LINE(indl), .RECEIVE_TIMING_LINE(rtl));
	dcl_remote_term term (.run(run), .rd_lvl(rd_lvl), .ind_lvl(ind_lvl),
		.rd_line(rdl), .ind_line(indl), .rt_line(rtl));
	// Adapter transmit clock: its own toggle, or the receive timing.
	always @(posedge clk) txc <= src ? ~txc : rx_t;

	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Writes wait for an edge; a read just after a write goes back to back.
	task automatic wrt(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		if (wr !== 1'b1) @(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	function automatic logic [7:0] st(input logic d, r, b);
		return {1'b0, d, 4'h3, r, b};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Watchdog: the tests need about 2 us, so this is ample.
	initial begin
		#20000;
		n_mismatch++;
		results;
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rdc(DCL_ADDR_LOOP_ID, {ID, 2'b00});
		rdc(DCL_ADDR_OPTION, 8'h00);
		$display("test 1 done");
		// Select low: status bit 0 follows the control bit.
		for (int i = 0; i < 4; i++) begin
			wrt(DCL_ADDR_LINECTL, 8'(i));
			rdc(DCL_ADDR_STATUS, st(1'b0, i[1], i[0]));
		end
		wrt(DCL_ADDR_STATUS, 8'h00);
		rdc(DCL_ADDR_STATUS, st(1'b0, 1'b1, 1'b1));
		$display("test 2 done");
		// Select high: bit 0 shows the indicator; the clock copy is unused.
		run <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			wrt(DCL_ADDR_OPTION, {6'h00, j[1], 1'b1});
			{src, rd_lvl, ind_lvl} <= {j[1], j[0], ~j[0]};
			repeat (4) @(posedge clk);
			#1 chk({7'h00, rx}, {7'h00, j[0]});
			rdc(DCL_ADDR_STATUS, st(j[0], 1'b1, ~j[0]));
		end
		$display("test 3 done");
		// Loop A wraps transmit data round while the line rests at mark.
		wrt(DCL_ADDR_OPTION, 8'h40);
		wrt(DCL_ADDR_LINECTL, 8'h80);
		rdc(DCL_ADDR_LOOP_ID, {ID, 2'b11});
		// The adapter strips the loop bits for the bare identifier.
		chk(rdata & 8'hfc, {ID, 2'b00});
		@(posedge clk);
		{tx, rd_lvl} <= 2'b01;
		repeat (3) @(posedge clk);
		#1 chk({6'h00, sdl, rx}, 8'h02);
		wrt(DCL_ADDR_LINECTL, 8'h00);
		rdc(DCL_ADDR_LOOP_ID, {ID, 2'b10});
		$display("test 4 done");
		// Clock enable low: a write is not taken and nothing moves.
		@(posedge clk);
		ce <= 1'b0;
		wrt(DCL_ADDR_LINECTL, 8'h03);
		@(posedge clk);
		ce <= 1'b1;
		rdc(DCL_ADDR_STATUS, st(1'b1, 1'b0, 1'b0));
		$display("test 5 done");
		results;
	end
endmodule
